// ---- rtl/ppc_consts.svh ----
// ppc_consts.svh: offsets, field positions and reset values of the
// port pin configuration block; assumes 8-bit register offsets.
`ifndef PPC_CONSTS_SVH
`define PPC_CONSTS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define PPC_OFS_PORTA_DATA   8'h00
`define PPC_OFS_PORTB_DATA   8'h01
`define PPC_OFS_PORTA_DIR    8'h02
`define PPC_OFS_PORTB_DIR    8'h03
`define PPC_OFS_PORTE_DATA   8'h08
`define PPC_OFS_PORTE_DIR    8'h09
`define PPC_OFS_PULLUP       8'h0C
`define PPC_OFS_LOWDRIVE     8'h0D
`define PPC_OFS_PWM_PAD      8'h54
`define PPC_OFS_PORTP_DATA   8'h56
`define PPC_OFS_PORTP_DIR    8'h57
`define PPC_OFS_TIMER_PAD    8'h8D
`define PPC_OFS_PORTT_DATA   8'hAE
`define PPC_OFS_PORTT_DIR    8'hAF
`define PPC_OFS_SERIAL_PAD   8'hD1
`define PPC_OFS_PORTS_DATA   8'hD6
`define PPC_OFS_PORTS_DIR    8'hD7
`define PPC_OFS_TW_PAD       8'hE5
`define PPC_OFS_TW_DATA      8'hE6
`define PPC_OFS_TW_DIR       8'hE7
`define PPC_OFS_PORTK_DATA   8'hFC
`define PPC_OFS_PORTK_DIR    8'hFD

// ---------------------------------------------------------------
// writable masks and reset values
// ---------------------------------------------------------------
`define PPC_MASK_PORTE_DIR   8'hFC
`define PPC_MASK_PULLUP      8'hF3
`define PPC_MASK_LOWDRIVE    8'hF3
`define PPC_MASK_PORTP       8'h0F
`define PPC_MASK_PORTK       8'h8F
`define PPC_MASK_TW          8'hC0
`define PPC_RST_PULLUP       8'h10
`define PPC_RST_LOWDRIVE     8'h00
`define PPC_RST_DIR          8'h00
`define PPC_RST_PWM_PAD      8'h00
`define PPC_RST_TIMER_PAD    8'h00
`define PPC_RST_SERIAL_PAD   8'h08
`define PPC_RST_TW_PAD       8'h00

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PPC_BIT_PA           0
`define PPC_BIT_PB           1
`define PPC_BIT_PE           4
`define PPC_BIT_PH           5
`define PPC_BIT_PJ           6
`define PPC_BIT_PK           7
`define PPC_BIT_PWM_PULL     0
`define PPC_BIT_PWM_LOWDRV   1
`define PPC_BIT_SER_PULL     3
`define PPC_BIT_SER_LOWDRV   4
`define PPC_BIT_TMR_PULL     5
`define PPC_BIT_TMR_LOWDRV   4
`define PPC_BIT_TW_PULL      4
`define PPC_BIT_TW_LOWDRV    3

`endif

// ---- rtl/ppc_pkg.sv ----
// ppc_pkg.sv: types of the port pin configuration block.
// assumes ppc_consts.svh holds all numeric constants.
package ppc_pkg;
  // operating mode handed in by the mode logic
  typedef enum logic [1:0] {
    PPC_MODE_SINGLE   = 2'b00,
    PPC_MODE_EXPANDED = 2'b01,
    PPC_MODE_PERIPH   = 2'b10
  } ppc_mode_t;
endpackage

// ---- rtl/ppc_pin_mux.sv ----
// ppc_pin_mux.sv: port pin configuration, direction registers, pull-up
// and reduced-drive controls, and pin ownership between GPIO and the
// peripherals. assumes mode and peripheral enables come from mclk logic.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_consts.svh"

module ppc_pin_mux
  import ppc_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  // mode and peripheral requests
  input  wire logic [1:0] modeSel,
  input  wire logic [15:0] extBusOut,
  input  wire logic [15:0] extBusOe,
  input  wire logic [7:0] busCtlOut,
  input  wire logic [7:0] busCtlOe,
  input  wire logic [7:0] emuPageOut,
  input  wire logic [3:0] pwmChanEn,
  input  wire logic [3:0] pwmOut,
  input  wire logic [7:0] timerEn,
  input  wire logic [7:0] timerOut,
  input  wire logic [7:0] timerOe,
  input  wire logic [7:0] serialEn,
  input  wire logic [7:0] serialOut,
  input  wire logic [7:0] serialOe,
  input  wire logic       twoWireEn,
  input  wire logic [1:0] twoWireLow,
  input  wire logic [2:0] canTxIn,
  // synchronised pin levels toward peripherals
  output logic      [2:0] canRxOut,
  output logic      [1:0] twoWireIn,
  output logic      [7:0] analogZeroIn,
  output logic      [7:0] analogOneIn,
  output logic      [7:0] pinTIn,
  output logic      [7:0] pinSIn,
  output logic      [7:0] pinEIn,
  // package pins
  input  wire logic [7:0] portAIn,
  output logic      [7:0] portAOut,
  output logic      [7:0] portAOe,
  input  wire logic [7:0] portBIn,
  output logic      [7:0] portBOut,
  output logic      [7:0] portBOe,
  input  wire logic [7:0] portEIn,
  output logic      [7:0] portEOut,
  output logic      [7:0] portEOe,
  input  wire logic [7:0] portKIn,
  output logic      [7:0] portKOut,
  output logic      [7:0] portKOe,
  input  wire logic [3:0] portPIn,
  output logic      [3:0] portPOut,
  output logic      [3:0] portPOe,
  input  wire logic [7:0] portTIn,
  output logic      [7:0] portTOut,
  output logic      [7:0] portTOe,
  input  wire logic [7:0] portSIn,
  output logic      [7:0] portSOut,
  output logic      [7:0] portSOe,
  input  wire logic [1:0] twPinIn,
  output logic      [1:0] twPinOut,
  output logic      [1:0] twPinOe,
  input  wire logic [2:0] canRxPin,
  output logic      [2:0] canTxPin,
  output logic      [2:0] canTxOe,
  input  wire logic [7:0] analogZeroPin,
  input  wire logic [7:0] analogOnePin,
  // pad controls
  output logic      [7:0] pullUpEn,
  output logic      [7:0] lowDriveEn,
  output logic      [2:0] canRxPullUp
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int SYNW = 73;
  logic [SYNW-1:0] syncMeta_r;
  logic [SYNW-1:0] syncPin_r;
  logic [SYNW-1:0] pinRaw;
  assign pinRaw = {portAIn, portBIn, portEIn, portKIn, portPIn, portTIn,
                   portSIn, twPinIn, canRxPin, analogZeroPin,
                   analogOnePin};

  // pins are asynchronous to mclk; meta stage feeds only the second
  always_ff @(posedge mclk) begin
    syncMeta_r <= pinRaw;
    syncPin_r  <= syncMeta_r;
  end

  logic [7:0] sA, sB, sE, sK, sT, sS;
  logic [3:0] sP;
  assign {sA, sB, sE, sK, sP, sT, sS, twoWireIn, canRxOut,
          analogZeroIn, analogOneIn} = syncPin_r;
  assign pinTIn = sT;
  assign pinSIn = sS;
  assign pinEIn = sE;

  // ---------------------------------------------------------------
  // map presence per mode
  // ---------------------------------------------------------------
  logic abMapped;
  logic padMapped;
  logic isExpanded;
  logic emuMode;
  assign isExpanded = (modeSel == PPC_MODE_EXPANDED);
  assign emuMode    = (modeSel != PPC_MODE_SINGLE);
  assign abMapped   = (modeSel == PPC_MODE_SINGLE);
  assign padMapped  = (modeSel != PPC_MODE_PERIPH);

  // write strobes; presence in the map gates them where they are used
  function automatic logic wrHit(input logic [7:0] ofs);
    wrHit = regWr && (regAddr == ofs);
  endfunction

  // ---------------------------------------------------------------
  // port A and B data and direction
  // ---------------------------------------------------------------
  logic [7:0] dataA_r, dataB_r, dirA_r, dirB_r;

  // any-time access whenever mapped, no other interlock
  always_ff @(posedge mclk) begin
    if (srst) begin
      dataA_r <= 8'h00;
      dataB_r <= 8'h00;
      dirA_r  <= `PPC_RST_DIR;
      dirB_r  <= `PPC_RST_DIR;
    end else if (abMapped) begin
      if (wrHit(`PPC_OFS_PORTA_DATA)) dataA_r <= regWrData;
      if (wrHit(`PPC_OFS_PORTB_DATA)) dataB_r <= regWrData;
      if (wrHit(`PPC_OFS_PORTA_DIR))  dirA_r  <= regWrData;
      if (wrHit(`PPC_OFS_PORTB_DIR))  dirB_r  <= regWrData;
    end
  end

  // ---------------------------------------------------------------
  // general direction and data registers of the other ports
  // ---------------------------------------------------------------
  logic [7:0] dataE_r, dirE_r, dataK_r, dirK_r, dataP_r, dirP_r;
  logic [7:0] dataT_r, dirT_r, dataS_r, dirS_r, dataW_r, dirW_r;

  always_ff @(posedge mclk) begin
    if (srst) begin
      {dataE_r, dataK_r, dataP_r} <= 24'h000000;
      {dataT_r, dataS_r, dataW_r} <= 24'h000000;
      {dirE_r, dirK_r, dirP_r}    <= {3{`PPC_RST_DIR}};
      {dirT_r, dirS_r, dirW_r}    <= {3{`PPC_RST_DIR}};
    end else begin
      if (wrHit(`PPC_OFS_PORTE_DATA)) dataE_r <= regWrData;
      if (wrHit(`PPC_OFS_PORTE_DIR))
        dirE_r <= regWrData & `PPC_MASK_PORTE_DIR;
      if (wrHit(`PPC_OFS_PORTK_DATA))
        dataK_r <= regWrData & `PPC_MASK_PORTK;
      if (wrHit(`PPC_OFS_PORTK_DIR) && !emuMode)
        dirK_r <= regWrData & `PPC_MASK_PORTK;
      if (wrHit(`PPC_OFS_PORTP_DATA))
        dataP_r <= regWrData & `PPC_MASK_PORTP;
      if (wrHit(`PPC_OFS_PORTP_DIR))
        dirP_r <= regWrData & `PPC_MASK_PORTP;
      if (wrHit(`PPC_OFS_PORTT_DATA)) dataT_r <= regWrData;
      if (wrHit(`PPC_OFS_PORTT_DIR))  dirT_r  <= regWrData;
      if (wrHit(`PPC_OFS_PORTS_DATA)) dataS_r <= regWrData;
      if (wrHit(`PPC_OFS_PORTS_DIR))  dirS_r  <= regWrData;
      if (wrHit(`PPC_OFS_TW_DATA))
        dataW_r <= regWrData & `PPC_MASK_TW;
      if (wrHit(`PPC_OFS_TW_DIR))
        dirW_r <= regWrData & `PPC_MASK_TW;
    end
  end

  // ---------------------------------------------------------------
  // pull-up and reduced-drive registers
  // ---------------------------------------------------------------
  logic [7:0] pullUp_r, lowDrv_r, pwmPad_r, tmrPad_r, serPad_r, twPad_r;
  logic       lowDrvLocked_r;

  // low drive takes one write only, so runaway code cannot weaken pads
  always_ff @(posedge mclk) begin
    if (srst) begin
      pullUp_r       <= `PPC_RST_PULLUP;
      lowDrv_r       <= `PPC_RST_LOWDRIVE;
      lowDrvLocked_r <= 1'b0;
    end else if (padMapped) begin
      if (wrHit(`PPC_OFS_PULLUP))
        pullUp_r <= regWrData & `PPC_MASK_PULLUP;
      if (wrHit(`PPC_OFS_LOWDRIVE) && !lowDrvLocked_r) begin
        lowDrv_r       <= regWrData & `PPC_MASK_LOWDRIVE;
        lowDrvLocked_r <= 1'b1;
      end
    end
  end

  // pad fields of the peripheral ports, any-time access
  always_ff @(posedge mclk) begin
    if (srst) begin
      pwmPad_r <= `PPC_RST_PWM_PAD;
      tmrPad_r <= `PPC_RST_TIMER_PAD;
      serPad_r <= `PPC_RST_SERIAL_PAD;
      twPad_r  <= `PPC_RST_TW_PAD;
    end else begin
      if (wrHit(`PPC_OFS_PWM_PAD))    pwmPad_r <= regWrData;
      if (wrHit(`PPC_OFS_TIMER_PAD))  tmrPad_r <= regWrData;
      if (wrHit(`PPC_OFS_SERIAL_PAD)) serPad_r <= regWrData;
      if (wrHit(`PPC_OFS_TW_PAD))     twPad_r  <= regWrData;
    end
  end

  // ---------------------------------------------------------------
  // pin ownership
  // ---------------------------------------------------------------
  // expanded: A/B carry address and data; peripheral: A/B hand to bus
  assign portAOut = abMapped ? dataA_r : extBusOut[15:8];
  assign portAOe  = abMapped ? dirA_r  : extBusOe[15:8];
  assign portBOut = abMapped ? dataB_r : extBusOut[7:0];
  assign portBOe  = abMapped ? dirB_r  : extBusOe[7:0];

  // port E: bus control in expanded mode, bits 1:0 never driven
  assign portEOut = isExpanded ? busCtlOut : dataE_r;
  assign portEOe  = (isExpanded ? busCtlOe : dirE_r)
                    & `PPC_MASK_PORTE_DIR;

  assign portKOut = emuMode ? emuPageOut : dataK_r;
  assign portKOe  = emuMode ? `PPC_MASK_PORTK : dirK_r;

  // a peripheral enable beats the GPIO direction bit pin by pin
  assign portPOut = (pwmChanEn & pwmOut) | (~pwmChanEn & dataP_r[3:0]);
  assign portPOe  = pwmChanEn | dirP_r[3:0];
  assign portTOut = (timerEn & timerOut) | (~timerEn & dataT_r);
  assign portTOe  = (timerEn & timerOe) | (~timerEn & dirT_r);
  assign portSOut = (serialEn & serialOut) | (~serialEn & dataS_r);
  assign portSOe  = (serialEn & serialOe) | (~serialEn & dirS_r);

  // two-wire pins are open drain while twoWireEn is set: only pulled low
  assign twPinOut = twoWireEn ? 2'b00 : dataW_r[7:6];
  assign twPinOe  = twoWireEn ? twoWireLow : dirW_r[7:6];

  // CAN pins belong to the controllers alone
  assign canTxPin    = canTxIn;
  assign canTxOe     = 3'b111;
  assign canRxPullUp = 3'b111;

  // a port's pull-up stays on while any pin of that port is an input
  logic [7:0] pullRaw;
  assign pullRaw = {pullUp_r[`PPC_BIT_PA], pullUp_r[`PPC_BIT_PB],
                    pullUp_r[`PPC_BIT_PE], pullUp_r[`PPC_BIT_PK],
                    pwmPad_r[`PPC_BIT_PWM_PULL],
                    tmrPad_r[`PPC_BIT_TMR_PULL],
                    serPad_r[`PPC_BIT_SER_PULL],
                    twPad_r[`PPC_BIT_TW_PULL]};
  assign pullUpEn = pullRaw & {|(~portAOe), |(~portBOe), |(~portEOe),
                    |(~portKOe), |(~portPOe), |(~portTOe),
                    |(~portSOe), |(~twPinOe)};
  assign lowDriveEn = {lowDrv_r[`PPC_BIT_PA], lowDrv_r[`PPC_BIT_PB],
                       lowDrv_r[`PPC_BIT_PE], lowDrv_r[`PPC_BIT_PK],
                       pwmPad_r[`PPC_BIT_PWM_LOWDRV],
                       tmrPad_r[`PPC_BIT_TMR_LOWDRV],
                       serPad_r[`PPC_BIT_SER_LOWDRV],
                       twPad_r[`PPC_BIT_TW_LOWDRV]};

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [7:0] rdNxt;
  logic [7:0] rdData_r;

  // data reads show the pin for inputs, the latch for outputs
  always_comb begin
    rdNxt = 8'h00;
    case (regAddr)
      `PPC_OFS_PORTA_DATA: rdNxt = abMapped ?
                         ((dirA_r & dataA_r) | (~dirA_r & sA)) : 8'h00;
      `PPC_OFS_PORTB_DATA: rdNxt = abMapped ?
                         ((dirB_r & dataB_r) | (~dirB_r & sB)) : 8'h00;
      `PPC_OFS_PORTA_DIR:  rdNxt = abMapped ? dirA_r : 8'h00;
      `PPC_OFS_PORTB_DIR:  rdNxt = abMapped ? dirB_r : 8'h00;
      `PPC_OFS_PORTE_DATA: rdNxt = (dirE_r & dataE_r) | (~dirE_r & sE);
      `PPC_OFS_PORTE_DIR:  rdNxt = dirE_r;
      `PPC_OFS_PULLUP:     rdNxt = padMapped ? pullUp_r : 8'h00;
      `PPC_OFS_LOWDRIVE:   rdNxt = padMapped ? lowDrv_r : 8'h00;
      `PPC_OFS_PWM_PAD:    rdNxt = pwmPad_r;
      `PPC_OFS_PORTP_DATA: rdNxt = {4'h0, (dirP_r[3:0] & dataP_r[3:0])
                                   | (~dirP_r[3:0] & sP)};
      `PPC_OFS_PORTP_DIR:  rdNxt = dirP_r;
      `PPC_OFS_TIMER_PAD:  rdNxt = tmrPad_r;
      `PPC_OFS_PORTT_DATA: rdNxt = (dirT_r & dataT_r) | (~dirT_r & sT);
      `PPC_OFS_PORTT_DIR:  rdNxt = dirT_r;
      `PPC_OFS_SERIAL_PAD: rdNxt = serPad_r;
      `PPC_OFS_PORTS_DATA: rdNxt = (dirS_r & dataS_r) | (~dirS_r & sS);
      `PPC_OFS_PORTS_DIR:  rdNxt = dirS_r;
      `PPC_OFS_TW_PAD:     rdNxt = twPad_r;
      `PPC_OFS_TW_DATA:    rdNxt = {(dirW_r[7:6] & dataW_r[7:6])
                                   | (~dirW_r[7:6] & twoWireIn), 6'h00};
      `PPC_OFS_TW_DIR:     rdNxt = dirW_r;
      `PPC_OFS_PORTK_DATA: rdNxt = ((dirK_r & dataK_r) | (~dirK_r & sK))
                                   & `PPC_MASK_PORTK;
      `PPC_OFS_PORTK_DIR:  rdNxt = dirK_r;
      default:             rdNxt = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (srst) rdData_r <= 8'h00;
    else      rdData_r <= regRd ? rdNxt : 8'h00;
  end
  assign regRdData = rdData_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_ab_bus;
    @(posedge mclk) disable iff (srst)
      isExpanded |-> (portAOut == extBusOut[15:8])
                  && (portBOe == extBusOe[7:0]);
  endproperty
  a_ab_bus: assert property (p_ab_bus)
    else $error("port A/B not handed to bus in expanded mode");

  property p_ab_data_rw;
    @(posedge mclk) disable iff (srst)
      (abMapped && dirA_r == 8'hFF && regWr
       && regAddr == `PPC_OFS_PORTA_DATA)
      ##1 !regWr
      ##1 (regRd && regAddr == `PPC_OFS_PORTA_DATA && dirA_r == 8'hFF
           && abMapped)
      |=> regRdData == $past(regWrData, 3);
  endproperty
  a_ab_data_rw: assert property (p_ab_data_rw)
    else $error("port A data did not read back");

  property p_ab_dir_gone;
    @(posedge mclk) disable iff (srst)
      (regRd && regAddr == `PPC_OFS_PORTA_DIR && !abMapped)
      |=> regRdData == 8'h00;
  endproperty
  a_ab_dir_gone: assert property (p_ab_dir_gone)
    else $error("port A direction visible outside single mode");

  property p_can_pins;
    @(posedge mclk) disable iff (srst)
      canTxOe == 3'b111 && canTxPin == canTxIn && canRxPullUp == 3'b111;
  endproperty
  a_can_pins: assert property (p_can_pins)
    else $error("CAN pins not dedicated");

  property p_tw_owner;
    @(posedge mclk) disable iff (srst)
      twoWireEn |-> twPinOut == 2'b00 && twPinOe == twoWireLow;
  endproperty
  a_tw_owner: assert property (p_tw_owner)
    else $error("two-wire pins not owned by module");

  property p_pe_input;
    @(posedge mclk) disable iff (srst) portEOe[1:0] == 2'b00;
  endproperty
  a_pe_input: assert property (p_pe_input)
    else $error("port E input pin driven");

  property p_pk_emu;
    @(posedge mclk) disable iff (srst)
      emuMode |-> portKOut == emuPageOut && portKOe == `PPC_MASK_PORTK;
  endproperty
  a_pk_emu: assert property (p_pk_emu)
    else $error("port K emulation signals missing");

  property p_pwm_own;
    @(posedge mclk) disable iff (srst)
      (portPOe & pwmChanEn) == pwmChanEn;
  endproperty
  a_pwm_own: assert property (p_pwm_own)
    else $error("enabled PWM pin not driven");

  property p_dir_out;
    @(posedge mclk) disable iff (srst)
      (wrHit(`PPC_OFS_PORTT_DIR) && timerEn == 8'h00)
      ##1 (timerEn == 8'h00) |-> portTOe == $past(regWrData);
  endproperty
  a_dir_out: assert property (p_dir_out)
    else $error("port T direction not applied");

  property p_reset_vals;
    @(posedge mclk) srst |=> pullUp_r == `PPC_RST_PULLUP
      && lowDrv_r == 8'h00 && dirA_r == 8'h00 && serPad_r[3];
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("wrong reset value");

  property p_lowdrv_once;
    @(posedge mclk) disable iff (srst)
      (lowDrvLocked_r && wrHit(`PPC_OFS_LOWDRIVE)) |=> $stable(lowDrv_r);
  endproperty
  a_lowdrv_once: assert property (p_lowdrv_once)
    else $error("low drive register changed twice");

  c_lowdrv_write: cover property (@(posedge mclk) disable iff (srst)
    wrHit(`PPC_OFS_LOWDRIVE) && !lowDrvLocked_r);
  c_expanded: cover property (@(posedge mclk) disable iff (srst)
    isExpanded && |extBusOe);
  c_pwm_take: cover property (@(posedge mclk) disable iff (srst)
    pwmChanEn == 4'hF);
  c_tw_on: cover property (@(posedge mclk) disable iff (srst)
    twoWireEn && |twoWireLow);

endmodule
`default_nettype wire

// ---- testbench/ppc_pin_partner.sv ----
// ppc_pin_partner.sv: far-side model of the package pins.
// assumes the bench supplies the board level of any undriven pin.
`timescale 1ns/1ps
`default_nettype none
module ppc_pin_partner (
  // board level seen where the device does not drive
  input  wire logic [7:0] extLvl,
  // device drive
  input  wire logic [7:0] aOut,
  input  wire logic [7:0] aOe,
  input  wire logic [7:0] eOut,
  input  wire logic [7:0] eOe,
  input  wire logic [2:0] txPin,
  // resolved levels
  output logic      [7:0] aIn,
  output logic      [7:0] eIn,
  output logic      [2:0] rxPin
);
  // device wins where it drives, the board elsewhere
  assign aIn = (aOe & aOut) | (~aOe & extLvl);
  // bits without drive (input-only ones too) follow the board
  assign eIn = (eOe & eOut) | (~eOe & extLvl);
  // transceiver echoes transmit onto receive, so rx sync is testable
  assign rxPin = txPin;
endmodule
`default_nettype wire

// ---- testbench/ppc_pin_mux_tb_top.sv ----
// ppc_pin_mux_tb_top.sv: self-checking bench of the pin mux.
// assumes the partner model resolves port A, port E and CAN pins.
`timescale 1ns/1ps
`default_nettype none
module ppc_pin_mux_tb_top;
  import ppc_pkg::*;
  logic mclk, srst, regWr, regRd, twoWireEn;
  logic [1:0] modeSel, twoWireLow, twoWireIn, twPinIn, twPinOut, twPinOe;
  logic [2:0] canTxIn, canRxOut, canRxPin, canTxPin, canTxOe, canRxPullUp;
  logic [3:0] pwmChanEn, pwmOut, portPIn, portPOut, portPOe;
  logic [15:0] extBusOut, extBusOe;
  logic [7:0] regAddr, regWrData, regRdData, busCtlOut, busCtlOe;
  logic [7:0] emuPageOut, timerEn, timerOut, timerOe, serialEn, serialOut;
  logic [7:0] serialOe, analogZeroIn, analogOneIn, pinTIn, pinSIn, pinEIn;
  logic [7:0] portAIn, portAOut, portAOe, portBIn, portBOut, portBOe;
  logic [7:0] portEIn, portEOut, portEOe, portKIn, portKOut, portKOe;
  logic [7:0] portTIn, portTOut, portTOe, portSIn, portSOut, portSOe;
  logic [7:0] analogZeroPin, analogOnePin, pullUpEn, lowDriveEn, extLvl;
  int n_fail = 0;
  int cmp_count = 0;
  // undriven pins of other ports follow the board level, analog one pins its inverse
  assign {portBIn, portKIn, portTIn, portSIn} = {4{extLvl}};
  assign portPIn = extLvl[3:0];
  assign twPinIn = extLvl[7:6];
  assign analogOnePin = ~extLvl;

  ppc_pin_mux u_ppc_pin_mux (.mclk, .srst, .regAddr, .regWrData, .regWr,
    .regRd, .regRdData, .modeSel, .extBusOut, .extBusOe, .busCtlOut,
    .busCtlOe, .emuPageOut, .pwmChanEn, .pwmOut, .timerEn, .timerOut,
    .timerOe, .serialEn, .serialOut, .serialOe, .twoWireEn, .twoWireLow,
    .canTxIn, .canRxOut, .twoWireIn, .analogZeroIn, .analogOneIn, .pinTIn,
    .pinSIn, .pinEIn, .portAIn, .portAOut, .portAOe, .portBIn, .portBOut,
    .portBOe, .portEIn, .portEOut, .portEOe, .portKIn, .portKOut, .portKOe,
    .portPIn, .portPOut, .portPOe, .portTIn, .portTOut, .portTOe, .portSIn,
    .portSOut, .portSOe, .twPinIn, .twPinOut, .twPinOe, .canRxPin,
    .canTxPin, .canTxOe, .analogZeroPin, .analogOnePin, .pullUpEn,
    .lowDriveEn, .canRxPullUp);
  ppc_pin_partner u_ppc_pin_partner (.extLvl(extLvl), .aOut(portAOut),
    .aOe(portAOe), .eOut(portEOut), .eOe(portEOe), .txPin(canTxPin),
    .aIn(portAIn), .eIn(portEIn), .rxPin(canRxPin));

  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk(regRdData, e);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd(8'h0C, 8'h10);
    rd(8'hD1, 8'h08);
    rd(8'h0D, 8'h00);
    rd(8'h02, 8'h00);
    chk(pullUpEn, 8'h22);
  endtask
  // lock must be the very first write to the low-drive register
  task automatic t_lock;
    wr(8'h0D, 8'hFF);
    rd(8'h0D, 8'hF3);
    chk(lowDriveEn, 8'hF0);
    wr(8'h0D, 8'h00);
    rd(8'h0D, 8'hF3);
  endtask
  task automatic t_dir;
    wr(8'h02, 8'hFF);
    wr(8'hAF, 8'h5A);
    wr(8'h00, 8'h96);
    rd(8'h00, 8'h96);
    chk(portAOe, 8'hFF);
    chk(portTOe, 16'h005A);
    chk(portAOut, 8'h96);
    rd(8'h03, 8'h00);
  endtask
  task automatic t_porte;
    wr(8'h09, 8'hFF);
    rd(8'h09, 8'hFC);
    chk(portEOe, 8'hFC);
  endtask
  // back in single mode the hidden registers must hold old values
  task automatic t_expand;
    @(posedge mclk);
    modeSel <= 2'b01;
    extBusOut <= 16'hA55A;
    extBusOe <= 16'hFFFF;
    busCtlOut <= 8'h5C;
    busCtlOe <= 8'hFF;
    emuPageOut <= 8'h81;
    rd(8'h02, 8'h00);
    chk({portAOut, portBOut}, 16'hA55A);
    chk({portAOe, portBOe}, 16'hFFFF);
    chk({portEOut, portEOe}, 16'h5CFC);
    chk({portKOut, portKOe}, 16'h818F);
    wr(8'h02, 8'h00);
    wr(8'hFD, 8'hFF);
    // peripheral mode hides the pull-up register as well
    modeSel <= 2'b10;
    wr(8'h0C, 8'hFF);
    rd(8'h0C, 8'h00);
    chk({portEOut, portEOe}, 16'h00FC);
    @(posedge mclk);
    modeSel <= 2'b00;
    rd(8'hFD, 8'h00);
    rd(8'h02, 8'hFF);
    rd(8'h0C, 8'h10);
  endtask
  task automatic t_periph;
    @(posedge mclk);
    pwmChanEn <= 4'hF;
    pwmOut <= 4'hA;
    timerEn <= 8'hFF;
    timerOut <= 8'h3C;
    timerOe <= 8'h0F;
    serialEn <= 8'hFF;
    serialOut <= 8'hC3;
    serialOe <= 8'hF0;
    twoWireEn <= 1'b1;
    twoWireLow <= 2'b10;
    @(posedge mclk);
    #1;
    chk({portPOut, portPOe}, 16'h00AF);
    chk({portTOut, portTOe}, 16'h3C0F);
    chk({portSOut, portSOe}, 16'hC3F0);
    chk({twPinOut, twPinOe}, 16'h0002);
  endtask
  task automatic t_can;
    @(posedge mclk);
    canTxIn <= 3'b101;
    analogZeroPin <= 8'h5A;
    extLvl <= 8'hB3;
    repeat (3) @(posedge mclk);
    #1;
    chk({canTxPin, canTxOe, canRxPullUp}, 16'h017F);
    chk(canRxOut, 16'h0005);
    chk(analogZeroIn, 16'h005A);
    chk(pinEIn, 16'h0003);
    chk(analogOneIn, 16'h004C);
    chk({pinTIn, pinSIn}, 16'hB3B3);
    chk(twoWireIn, 16'h0002);
  endtask

  // clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    summarize();
  end
  // main sequence, every input set at time zero
  initial begin
    {srst, regWr, regRd, twoWireEn} = 4'h8;
    {modeSel, twoWireLow, canTxIn, pwmChanEn, pwmOut} = '0;
    {regAddr, regWrData, busCtlOut, busCtlOe, emuPageOut} = '0;
    {timerEn, timerOut, timerOe, serialEn, serialOut, serialOe} = '0;
    {extBusOut, extBusOe, analogZeroPin, extLvl} = '0;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_lock();
    t_dir();
    t_porte();
    t_expand();
    t_periph();
    t_can();
    summarize();
  end
endmodule
`default_nettype wire
